// [pbs_checker.sv]
`timescale 1ns/1ps
module pbs_checker
#(
  parameter bit ENABLE_ACTIVE_HIGH = 1'b1,
  parameter int unsigned TICK_CYCLES = pbs_pkg::TICK_CYC,
  parameter int unsigned REQ_FILT_CYCLES = pbs_pkg::REQ_MIN_PW_CYC
)
(
  // Clock and reset
  input logic ref_clk,
  input logic rst_n,
  // Pins
  input logic push_button_n,
  input logic shutdown_req_n,
  input pbs_pkg::pbs_ext_s ext,
  input logic power_enable,
  input logic power_int_n
);
  import pbs_pkg::*;
  localparam int unsigned T = TICK_CYCLES;
  logic on;
  logic was_on_r;
  int unsigned btn_r, on_r, off_r, int_r, req_r;
  // ==========
  // Run lengths in cycles; the tick phase allows one tick of slack
  assign on = power_enable == ENABLE_ACTIVE_HIGH;
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      btn_r <= '0;
      on_r <= '0;
      off_r <= '0;
      int_r <= '0;
      req_r <= '0;
      was_on_r <= 1'b0;
    end
    else
    begin
      btn_r <= push_button_n ? '0 : btn_r + 1;
      on_r <= on ? on_r + 1 : '0;
      off_r <= on ? '0 : off_r + 1;
      int_r <= power_int_n ? '0 : int_r + 1;
      req_r <= shutdown_req_n ? '0 : req_r + 1;
      was_on_r <= was_on_r | on;
    end
  end
  // ==========
  // Properties
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  reset_state_a: assert property (@(posedge ref_clk) disable iff (1'b0) !rst_n |=> !on && power_int_n)
    else $error("outputs not idle after reset");
  on_debounce_a: assert property ($rose(on) |-> btn_r >= (ON_DEBOUNCE_TICKS - 1) * T)
    else $error("enable before turn-on debounce");
  blank_hold_a: assert property ($fell(on) |-> on_r >= (BLANK_TICKS - 1) * T)
    else $error("enable dropped inside blanking");
  off_debounce_a: assert property ($fell(power_int_n) |-> btn_r >= (OFF_DEBOUNCE_TICKS + ext.off_debounce_extend - 1) * T)
    else $error("interrupt before turn-off debounce");
  int_in_run_a: assert property ($fell(power_int_n) |-> on && on_r >= (BLANK_TICKS + RELEASE_DB_TICKS - 1) * T)
    else $error("interrupt outside normal run");
  int_with_on_a: assert property (!power_int_n |-> on)
    else $error("interrupt held after release");
  failsafe_a: assert property (int_r <= (FAILSAFE_TICKS + ext.shutdown_timeout_extend + 1) * T)
    else $error("failsafe timeout overrun");
  req_release_a: assert property (req_r >= REQ_FILT_CYCLES + 4 && on_r > (BLANK_TICKS + 2) * T |-> !on)
    else $error("request low did not release enable");
  lockout_a: assert property ($rose(on) && was_on_r |-> off_r >= (LOCKOUT_TICKS + ON_DEBOUNCE_TICKS - 2) * T)
    else $error("turn-on inside lockout");
  cover property ($fell(power_int_n));
  cover property ($rose(on) && was_on_r);
  cover property ($fell(on) && !power_int_n);
endmodule

// [pbs_input_cond.sv]
`timescale 1ns/1ps
module pbs_input_cond
  import pbs_pkg::*;
#(
  parameter int unsigned REQ_FILT_CYCLES = REQ_MIN_PW_CYC
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Raw pins
  input wire logic push_button_n,
  input wire logic shutdown_req_n,
  // Conditioned levels
  output pbs_pkg::pbs_inputs_s cond
);

  logic [1:0] pb_sync_r;
  logic [1:0] req_sync_r;
  logic [FILT_W-1:0] req_cnt_r;
  logic [FILT_W-1:0] req_cnt_nxt;
  logic req_low_r;
  wire req_raw_low;

  // ==========================================
  // Synchronisers
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      pb_sync_r <= 2'h3;
      req_sync_r <= 2'h3;
    end
    else
    begin
      pb_sync_r <= {pb_sync_r[0], push_button_n}; // RULE20
      req_sync_r <= {req_sync_r[0], shutdown_req_n}; // RULE20
    end
  end

  // ==========================================
  // Pulse-width filter: a high sample clears the count, so short glitches never qualify
  assign req_raw_low = ~req_sync_r[1];
  assign req_cnt_nxt = !req_raw_low ? '0 :
                       (req_cnt_r == FILT_W'(REQ_FILT_CYCLES)) ? req_cnt_r : req_cnt_r + FILT_W'(1);

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      req_cnt_r <= '0;
      req_low_r <= 1'b0;
    end
    else
    begin
      req_cnt_r <= req_cnt_nxt;
      req_low_r <= (req_cnt_nxt == FILT_W'(REQ_FILT_CYCLES)); // RULE17
    end
  end

  assign cond.button_low = ~pb_sync_r[1];
  assign cond.request_low = req_low_r;

endmodule

// [pbs_partner.sv]
`timescale 1ns/1ps
module pbs_partner
#(
  parameter int unsigned TICK_CYCLES = pbs_pkg::TICK_CYC
)
(
  // Clock
  input logic ref_clk,
  // Bench controls: mode 0 dead host, 1 normal, 2 hung after boot, 3 interrupt tied to request
  input logic press,
  input logic glitch,
  input logic [1:0] mode,
  // Device pins
  input logic power_enable,
  input logic power_int_n,
  output logic push_button_n,
  output logic shutdown_req_n
);
  import pbs_pkg::*;
  localparam int unsigned BOOT = 50 * TICK_CYCLES;
  localparam int unsigned HOUSE = 5 * TICK_CYCLES;
  int unsigned up_r, hk_r;
  logic req_r;
  // ==========
  // Pull-up on the switch: an open contact reads high
  assign push_button_n = ~press;
  assign shutdown_req_n = (mode == 2'h3 ? power_int_n : req_r) & ~glitch;
  always_ff @(posedge ref_clk)
  begin
    up_r <= power_enable ? up_r + 1 : 0;
    hk_r <= power_int_n ? 0 : hk_r + 1;
    // An unpowered host cannot hold the request high
    if (power_enable !== 1'b1)
      req_r <= 1'b0;
    else if (mode != 2'h0 && up_r == BOOT)
      req_r <= 1'b1;
    else if (mode == 2'h1 && hk_r == HOUSE)
      req_r <= 1'b0;
  end
endmodule

// [pbs_pkg.sv]
// Behaviour
// RULE1: Enable asserts only after the button has been low continuously for the turn-on debounce time.
// RULE2: Button high before turn-on debounce completes restarts that debounce count.
// RULE3: After enable asserts, the blanking timer runs and both inputs are ignored.
// RULE4: Shutdown request still low when blanking ends releases the enable.
// RULE5: After blanking, the button release is debounced by a fixed timer.
// RULE6: Interrupt goes low after the button is held for base plus extension debounce.
// RULE7: Button high during turn-off debounce restarts it without raising an interrupt.
// RULE8: With zero extension, turn-off debounce is only the fixed base time.
// RULE9: Failsafe timer starts at interrupt; expiry with request high releases enable.
// RULE10: Failsafe timeout is lengthened by a configurable extra delay.
// RULE11: Shutdown request low after blanking releases enable at once, ending failsafe.
// RULE12: After power-off, the release is debounced, then idle awaits a new press.
// RULE13: Enable polarity selectable: active high or active low.
// RULE14: At reset enable is released and the interrupt is not asserted.
// RULE15: Host raises the request within blanking and lowers it after housekeeping.
// RULE16: Host may tie the interrupt to the request for immediate release.
// RULE17: A low request is acted on only after persisting the minimum pulse width.
// RULE18: After enable release, the button is ignored for the lockout period.
// RULE19: All periods count ticks of one timebase; extensions are tick parameters.
// RULE20: Button and request inputs are synchronised before use.
package pbs_pkg;

  // ==========================================
  // Timebase
  localparam int unsigned CLK_HZ = 100000000;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000000 * TICK_US;
  localparam int unsigned TICK_W = 17;

  // ==========================================
  // Periods in ms and their tick counts
  localparam int unsigned ON_DEBOUNCE_MS = 128;
  localparam int unsigned BLANK_MS = 512;
  localparam int unsigned RELEASE_DB_MS = 32;
  localparam int unsigned OFF_DEBOUNCE_MS = 32;
  localparam int unsigned FAILSAFE_MS = 128;
  localparam int unsigned LOCKOUT_MS = 256;
  localparam int unsigned ON_DEBOUNCE_TICKS = ON_DEBOUNCE_MS * 1000 / TICK_US;
  localparam int unsigned BLANK_TICKS = BLANK_MS * 1000 / TICK_US;
  localparam int unsigned RELEASE_DB_TICKS = RELEASE_DB_MS * 1000 / TICK_US;
  localparam int unsigned OFF_DEBOUNCE_TICKS = OFF_DEBOUNCE_MS * 1000 / TICK_US;
  localparam int unsigned FAILSAFE_TICKS = FAILSAFE_MS * 1000 / TICK_US;
  localparam int unsigned LOCKOUT_TICKS = LOCKOUT_MS * 1000 / TICK_US;
  localparam int unsigned TMR_W = 16;

  // ==========================================
  // Shutdown request glitch filter, rounded up to whole cycles
  localparam int unsigned REQ_MIN_PW_NS = 30000;
  localparam int unsigned CLK_PERIOD_NS = 1000000000 / CLK_HZ;
  localparam int unsigned REQ_MIN_PW_CYC = (REQ_MIN_PW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FILT_W = 12;

  // ==========================================
  // Sequencer states
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'h0,
    ST_ON_DB = 3'h1,
    ST_BLANK = 3'h2,
    ST_REL_DB = 3'h3,
    ST_RUN = 3'h4,
    ST_OFF_DB = 3'h5,
    ST_FAILSAFE = 3'h6,
    ST_LOCKOUT = 3'h7
  } pbs_state_e;

  // Clean inputs after synchronisers and filtering
  typedef struct packed
  {
    logic button_low;
    logic request_low;
  } pbs_inputs_s;

  // Extension delays in ticks
  typedef struct packed
  {
    logic [TMR_W-1:0] off_debounce_extend;
    logic [TMR_W-1:0] shutdown_timeout_extend;
  } pbs_ext_s;

endpackage

// [pbs_sequencer.sv]
`timescale 1ns/1ps
module pbs_sequencer
  import pbs_pkg::*;
#(
  parameter bit ENABLE_ACTIVE_HIGH = 1'b1,
  // Tick and filter lengths in cycles; a bench may shorten both to keep runs brief
  parameter int unsigned TICK_CYCLES = TICK_CYC,
  parameter int unsigned REQ_FILT_CYCLES = REQ_MIN_PW_CYC
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Button and host pins
  input wire logic push_button_n,
  input wire logic shutdown_req_n,
  // Extension settings in ticks
  input pbs_pkg::pbs_ext_s ext,
  // Outputs
  output logic power_enable,
  output logic power_int_n
);
  import pbs_pkg::*;

  pbs_inputs_s cond;
  pbs_state_e state_r;
  pbs_state_e state_nxt;
  logic [TICK_W-1:0] tick_cnt_r;
  logic [TMR_W-1:0] tmr_r;
  logic [TMR_W-1:0] tmr_nxt;
  logic enable_on_r;
  logic enable_on_nxt;
  logic power_enable_r;
  logic power_int_n_r;
  logic power_int_n_nxt;
  logic [TMR_W-1:0] rel_r;
  wire tick;
  wire tmr_clear;
  wire btn;
  wire req;

  pbs_input_cond #(.REQ_FILT_CYCLES(REQ_FILT_CYCLES)) u_cond
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .push_button_n(push_button_n),
    .shutdown_req_n(shutdown_req_n),
    .cond(cond)
  );

  assign btn = cond.button_low;
  assign req = cond.request_low;

  // ==========================================
  // Timebase
  assign tick = (tick_cnt_r == TICK_W'(TICK_CYCLES - 1)); // RULE19

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      tick_cnt_r <= '0;
    else
      tick_cnt_r <= tick ? '0 : tick_cnt_r + TICK_W'(1);
  end

  // ==========================================
  // State targets; extension sums are wide enough that a full extension cannot wrap
  wire [TMR_W:0] off_target = (TMR_W+1)'(OFF_DEBOUNCE_TICKS) + {1'b0, ext.off_debounce_extend}; // RULE8
  wire [TMR_W:0] kill_target = (TMR_W+1)'(FAILSAFE_TICKS) + {1'b0, ext.shutdown_timeout_extend}; // RULE10
  wire [TMR_W:0] tmr_ext = {1'b0, tmr_r};
  wire on_db_done = (tmr_r == TMR_W'(ON_DEBOUNCE_TICKS));
  wire blank_done = (tmr_r == TMR_W'(BLANK_TICKS));
  wire rel_done = (tmr_r == TMR_W'(RELEASE_DB_TICKS));
  wire off_done = (tmr_ext >= off_target);
  // The timer saturates, so a failsafe target beyond its range ends at full scale instead of never
  wire kill_done = (tmr_ext >= kill_target) || (tmr_r == '1);
  wire lock_done = (tmr_r == TMR_W'(LOCKOUT_TICKS));
  wire rel_ok = (rel_r == TMR_W'(RELEASE_DB_TICKS));

  // ==========================================
  // Sequencer
  always_comb
  begin
    state_nxt = state_r;
    enable_on_nxt = enable_on_r;
    power_int_n_nxt = power_int_n_r;
    case (state_r)
      ST_IDLE:
      begin
        if (btn)
          state_nxt = ST_ON_DB;
      end
      ST_ON_DB:
      begin
        if (!btn)
          state_nxt = ST_IDLE; // RULE2
        else if (on_db_done)
        begin
          state_nxt = ST_BLANK;
          enable_on_nxt = 1'b1; // RULE1
        end
      end
      ST_BLANK:
      begin
        // Both inputs ignored until the window ends
        if (blank_done) // RULE3
        begin
          if (req)
          begin
            state_nxt = ST_LOCKOUT;
            enable_on_nxt = 1'b0; // RULE4
          end
          else
            state_nxt = ST_REL_DB; // RULE5
        end
      end
      ST_REL_DB:
      begin
        if (req)
        begin
          state_nxt = ST_LOCKOUT;
          enable_on_nxt = 1'b0; // RULE11
        end
        else if (rel_done)
          state_nxt = ST_RUN; // RULE5
      end
      ST_RUN:
      begin
        if (req)
        begin
          state_nxt = ST_LOCKOUT;
          enable_on_nxt = 1'b0; // RULE11
        end
        else if (btn)
          state_nxt = ST_OFF_DB;
      end
      ST_OFF_DB:
      begin
        if (req)
        begin
          state_nxt = ST_LOCKOUT;
          enable_on_nxt = 1'b0; // RULE11
        end
        else if (!btn)
          state_nxt = ST_RUN; // RULE7
        else if (off_done)
        begin
          state_nxt = ST_FAILSAFE;
          power_int_n_nxt = 1'b0; // RULE6
        end
      end
      ST_FAILSAFE:
      begin
        if (req || kill_done) // RULE9 RULE11
        begin
          state_nxt = ST_LOCKOUT;
          enable_on_nxt = 1'b0;
          power_int_n_nxt = 1'b1;
        end
      end
      ST_LOCKOUT:
      begin
        // Button ignored until lockout ends and the button has been seen high for the release time
        if (lock_done && rel_ok) // RULE18 RULE12
          state_nxt = ST_IDLE;
      end
      default:
      begin
        state_nxt = ST_IDLE;
        enable_on_nxt = 1'b0;
        power_int_n_nxt = 1'b1;
      end
    endcase
  end

  // ==========================================
  // Shared timer: restarts on every state change; in lockout it counts released-button
  // time separately so the release debounce and the lockout overlap
  wire in_lock = (state_r == ST_LOCKOUT);
  assign tmr_clear = (state_nxt != state_r);

  always_comb
  begin
    tmr_nxt = tmr_r;
    if (tmr_clear)
      tmr_nxt = '0;
    else if (state_r == ST_REL_DB && btn)
      tmr_nxt = '0; // RULE5
    else if (tick && !(tmr_r == '1))
      tmr_nxt = tmr_r + TMR_W'(1);
    if (in_lock && !tmr_clear && (tmr_r == TMR_W'(LOCKOUT_TICKS)))
      tmr_nxt = tmr_r;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      rel_r <= '0;
    else if (!in_lock || btn)
      rel_r <= '0; // RULE12
    else if (tick && !rel_ok)
      rel_r <= rel_r + TMR_W'(1);
  end

  // ==========================================
  // Registers
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state_r <= ST_IDLE;
      tmr_r <= '0;
      enable_on_r <= 1'b0; // RULE14
      power_enable_r <= ~ENABLE_ACTIVE_HIGH; // RULE14
      power_int_n_r <= 1'b1; // RULE14
    end
    else
    begin
      state_r <= state_nxt;
      tmr_r <= tmr_nxt;
      enable_on_r <= enable_on_nxt;
      power_enable_r <= enable_on_nxt ~^ ENABLE_ACTIVE_HIGH; // RULE13
      power_int_n_r <= power_int_n_nxt;
    end
  end

  assign power_enable = power_enable_r;
  assign power_int_n = power_int_n_r;

endmodule

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import pbs_pkg::*;
  // Short tick keeps the run small; the request filter stays well under one tick as in hardware
  localparam int unsigned SIM_TICK = 16;
  localparam int unsigned SIM_FILT = 4;
  localparam int unsigned GLITCH_CYC = 2;
  localparam int unsigned WATCHDOG_CYC = 90000;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic press = 1'b0;
  logic glitch = 1'b0;
  logic [1:0] mode = 2'h0;
  logic push_button_n, shutdown_req_n, power_enable, power_enable_n, power_int_n;
  pbs_ext_s ext = '{off_debounce_extend: 16'h0002, shutdown_timeout_extend: 16'h0003};
  int mismatches = 0;
  int checked = 0;
  int t;
  always #5 ref_clk = ~ref_clk;
  pbs_partner #(.TICK_CYCLES(SIM_TICK)) i_pbs_partner (.ref_clk, .press, .glitch, .mode, .power_enable,
    .power_int_n, .push_button_n, .shutdown_req_n);
  pbs_sequencer #(.ENABLE_ACTIVE_HIGH(1'b1), .TICK_CYCLES(SIM_TICK), .REQ_FILT_CYCLES(SIM_FILT)) i_pbs_sequencer
    (.ref_clk, .rst_n, .push_button_n, .shutdown_req_n, .ext, .power_enable, .power_int_n);
  // Second polarity sees the same pins, so it must mirror the first
  pbs_sequencer #(.ENABLE_ACTIVE_HIGH(1'b0), .TICK_CYCLES(SIM_TICK), .REQ_FILT_CYCLES(SIM_FILT)) i_pbs_sequencer_n
    (.ref_clk, .rst_n, .push_button_n, .shutdown_req_n, .ext, .power_enable(power_enable_n), .power_int_n());
  // ==========
  // Helpers
  task check(string name, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  // Tick phase makes every period uncertain by one tick
  task near(string name, int ms, int exp);
    check(name, (ms >= exp - 1 && ms <= exp + 1) ? 32'(exp) : 32'(ms), 32'(exp));
  endtask
  task step(logic p, int ms);
    @(posedge ref_clk);
    press <= p;
    repeat (ms * SIM_TICK) @(posedge ref_clk);
  endtask
  task wait_for(logic which, logic lvl, int max_ms, output int ms);
    int n;
    n = 0;
    while (((which ? power_int_n : power_enable) !== lvl) && n < max_ms * SIM_TICK)
    begin
      @(negedge ref_clk);
      n++;
    end
    ms = (n + SIM_TICK / 2) / SIM_TICK;
  endtask
  // ==========
  // Scenarios
  task test_reset;
    @(negedge ref_clk);
    check("enable", power_enable, 1'b0);
    check("enable_n", power_enable_n, 1'b1);
    check("int", power_int_n, 1'b1);
  endtask
  task test_abort;
    step(1, 20);
    step(0, 5);
    step(1, 0);
    wait_for(0, 1, 200, t);
    near("on_debounce", t, 128);
    check("enable_n_on", power_enable_n, 1'b0);
    wait_for(0, 0, 600, t);
    near("abort", t, 512);
    check("enable_n_off", power_enable_n, 1'b1);
    step(0, 320);
  endtask
  task test_host;
    @(posedge ref_clk);
    mode <= 2'h1;
    step(1, 0);
    wait_for(0, 1, 200, t);
    step(1, 600);
    check("int_held_press", power_int_n, 1'b1);
    check("enable_up", power_enable, 1'b1);
    step(0, 40);
    @(posedge ref_clk);
    glitch <= 1'b1;
    repeat (GLITCH_CYC) @(posedge ref_clk);
    glitch <= 1'b0;
    step(1, 10);
    step(0, 5);
    check("glitch", power_enable, 1'b1);
    check("short_press", power_int_n, 1'b1);
    step(1, 0);
    wait_for(1, 0, 60, t);
    near("off_debounce", t, 34);
    wait_for(0, 0, 20, t);
    near("host_release", t, 5);
    check("int_cleared", power_int_n, 1'b1);
    step(0, 320);
  endtask
  task test_failsafe;
    @(posedge ref_clk);
    mode <= 2'h2;
    step(1, 0);
    wait_for(0, 1, 500, t);
    near("on_after_lockout", t, 128);
    step(0, 600);
    step(1, 0);
    wait_for(1, 0, 60, t);
    near("off_debounce", t, 34);
    wait_for(0, 0, 200, t);
    near("failsafe", t, 131);
  endtask
  task test_tied;
    @(posedge ref_clk);
    mode <= 2'h3;
    step(1, 0);
    wait_for(0, 1, 200, t);
    near("tied_on", t, 128);
    step(0, 560);
    step(1, 0);
    wait_for(1, 0, 60, t);
    near("tied_off_db", t, 34);
    wait_for(0, 0, 5, t);
    near("tied_release", t, 0);
    check("tied_int", power_int_n, 1'b1);
    check("tied_enable_n", power_enable_n, 1'b1);
    step(0, 320);
  endtask
  task summarize;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    test_reset;
    test_abort;
    test_host;
    test_tied;
    test_failsafe;
    summarize;
  end
  // Scenarios need about 4100 ticks; the limit leaves margin above that
  initial
  begin
    repeat (WATCHDOG_CYC) @(posedge ref_clk);
    mismatches++;
    summarize;
  end
endmodule
bind pbs_sequencer pbs_checker #(.ENABLE_ACTIVE_HIGH(ENABLE_ACTIVE_HIGH), .TICK_CYCLES(TICK_CYCLES),
  .REQ_FILT_CYCLES(REQ_FILT_CYCLES)) i_pbs_checker (.ref_clk, .rst_n,
  .push_button_n, .shutdown_req_n, .ext, .power_enable, .power_int_n);
